// [rtl/shift_table_decoder.sv]
// Purpose: decodes shift/rotate and table interpolate instruction words from fetch
// Assumes: fetch words come from logic on pclk; the extension word follows its first word
// Notes: results and counters are readable over APB; decode can be paused from CTRL
`timescale 1ns/1ps

// What this block does
// - count-source bit clear: the count/register field is an immediate shift count.
// - count-source bit set: that field names the data register holding the count.
// - direction bit 0 means right, 1 means left, in every shift form.
// - size field 00 byte, 01 word, 10 long for shifts and tables.
// - extension rounding bit 0 unrounded, 1 rounded, for all table variants.
// - unsigned data-register interpolate: prefix first word, extension bits 9-8 zero.
// - unsigned lookup: prefix plus address, extension bit 15 clear, bits 9-8 01.
// - signed data-register interpolate differs only by extension bit 11 set.
// - signed lookup matches unsigned lookup except extension bit 11 set.
// - signed rounded gives a signed rounded result; plain variant skips rounding.
module shift_table_decoder
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [decode_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// instruction words from fetch
	input decode_pkg::fetch_t fetch,
	// decoded result
	output logic dec_valid,
	output decode_pkg::decode_t dec_out,
	output logic waiting_ext
);
	import decode_pkg::*;

	// ****************************************
	// state
	// ****************************************
	dec_state_t state_r;
	dec_state_t state_nxt;
	logic enable_r;
	logic [15:0] held_first_r;
	logic [15:0] held_ext_r;
	logic [15:0] count_r;
	logic dec_valid_r;
	decode_t dec_r;
	decode_t dec_comb;
	logic needs_ext;
	logic take_first;
	logic take_ext;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic apb_write;
	logic [15:0] dec_first_word;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		reg_hit = (a == CTRL_OFS) || (a == STATUS_OFS) || (a == DEC_OFS) || (a == WORDS_OFS);
	endfunction

	assign take_first = fetch.valid && enable_r && (state_r == ST_FIRST);
	assign take_ext = fetch.valid && enable_r && (state_r == ST_EXT);
	assign dec_first_word = (state_r == ST_EXT) ? held_first_r : fetch.word;
	assign apb_write = psel && penable && pready_r && pwrite && reg_hit(paddr);

	instr_field_decoder u_fields
	(
		.first_word(dec_first_word),
		.ext_word(fetch.word),
		.ext_present(state_r == ST_EXT),
		.dec(dec_comb),
		.needs_ext(needs_ext)
	);

	// ****************************************
	// word sequencing
	// ****************************************
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_FIRST:
			begin
				if (take_first && needs_ext)
				begin
					state_nxt = ST_EXT;
				end
			end
			ST_EXT:
			begin
				// pausing drops a half-read table pair rather than mixing streams
				if (take_ext || !enable_r)
				begin
					state_nxt = ST_FIRST;
				end
			end
			default: state_nxt = ST_FIRST;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= ST_FIRST;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			held_first_r <= 16'h0000;
			held_ext_r <= 16'h0000;
		end
		else if (take_first)
		begin
			held_first_r <= fetch.word;
			held_ext_r <= 16'h0000;
		end
		else if (take_ext)
		begin
			held_ext_r <= fetch.word;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dec_valid_r <= 1'b0;
			dec_r <= '0;
		end
		else
		begin
			dec_valid_r <= (take_first && !needs_ext) || take_ext;
			if ((take_first && !needs_ext) || take_ext)
			begin
				dec_r <= dec_comb;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_r <= COUNT_RST;
		end
		else if (apb_write && (paddr == STATUS_OFS))
		begin
			count_r <= COUNT_RST;
		end
		else if (dec_valid_r)
		begin
			count_r <= count_r + 16'h0001;
		end
	end

	// ****************************************
	// apb slave: setup cycle loads the answer, access phase lasts one cycle
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enable_r <= CTRL_EN_RST;
		end
		else if (apb_write && (paddr == CTRL_OFS))
		begin
			enable_r <= pwdata[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= PRDATA_RST;
		end
		else
		begin
			pready_r <= psel && !penable;
			pslverr_r <= psel && !penable && !reg_hit(paddr);
			if (psel && !penable)
			begin
				case (paddr)
					CTRL_OFS: prdata_r <= {31'h0000_0000, enable_r};
					STATUS_OFS: prdata_r <= {count_r, 13'h0000, dec_r.illegal, dec_valid_r,
						state_r == ST_EXT};
					DEC_OFS: prdata_r <= {1'b0, dec_r};
					WORDS_OFS: prdata_r <= {held_first_r, held_ext_r};
					default: prdata_r <= PRDATA_RST;
				endcase
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign dec_valid = dec_valid_r;
	assign dec_out = dec_r;
	assign waiting_ext = (state_r == ST_EXT);

	// ****************************************
	// checks
	// ****************************************
	property p_imm_count;
		@(posedge pclk) disable iff (!presetn)
		take_first && (fetch.word[15:12] == SHIFT_GRP) && (fetch.word[7:6] != SZ_MEM)
			&& !fetch.word[5] |=> dec_valid_r && !dec_r.count_is_reg && !dec_r.is_mem
			&& (dec_r.count_or_reg == $past(fetch.word[11:9]));
	endproperty
	a_imm_count: assert property (p_imm_count) else $error("immediate count misdecoded");

	property p_reg_count;
		@(posedge pclk) disable iff (!presetn)
		take_first && (fetch.word[15:12] == SHIFT_GRP) && (fetch.word[7:6] != SZ_MEM)
			&& fetch.word[5] |=> dec_r.count_is_reg
			&& (dec_r.count_or_reg == $past(fetch.word[11:9]));
	endproperty
	a_reg_count: assert property (p_reg_count) else $error("count register misdecoded");

	property p_direction;
		@(posedge pclk) disable iff (!presetn)
		take_first && (fetch.word[15:12] == SHIFT_GRP)
			&& ((fetch.word[7:6] != SZ_MEM) || !fetch.word[11])
			|=> dec_r.dir_left == $past(fetch.word[8]);
	endproperty
	a_direction: assert property (p_direction) else $error("shift direction wrong");

	property p_size;
		@(posedge pclk) disable iff (!presetn)
		take_first && (fetch.word[15:12] == SHIFT_GRP) && (fetch.word[7:6] != SZ_MEM)
			|=> dec_r.size == $past(fetch.word[7:6]);
	endproperty
	a_size: assert property (p_size) else $error("operand size wrong");

	property p_round;
		@(posedge pclk) disable iff (!presetn)
		take_ext |=> dec_valid_r && (dec_r.tbl_round == $past(fetch.word[10]));
	endproperty
	a_round: assert property (p_round) else $error("rounding bit wrong");

	property p_table_pair;
		@(posedge pclk) disable iff (!presetn)
		take_first && (fetch.word[15:6] == TBL_PREFIX) |=> !dec_valid_r && waiting_ext;
	endproperty
	a_table_pair: assert property (p_table_pair) else $error("table word not held");

	property p_signed;
		@(posedge pclk) disable iff (!presetn)
		take_ext |=> dec_r.tbl_signed == $past(fetch.word[11]);
	endproperty
	a_signed: assert property (p_signed) else $error("signedness bit wrong");

	property p_signed_op;
		@(posedge pclk) disable iff (!presetn)
		dec_valid_r && !dec_r.illegal && dec_r.tbl_signed && dec_r.tbl_round
			|-> dec_r.op == signed_rounded_interp_op;
	endproperty
	a_signed_op: assert property (p_signed_op) else $error("signed rounded op wrong");

	property p_mem_kind;
		@(posedge pclk) disable iff (!presetn)
		take_first && (fetch.word[15:12] == SHIFT_GRP) && (fetch.word[7:6] == SZ_MEM)
			&& !fetch.word[11] |=> dec_r.is_mem && (dec_r.op != no_group_op);
	endproperty
	a_mem_kind: assert property (p_mem_kind) else $error("memory shift misdecoded");

endmodule

// [rtl/decode_pkg.sv]
// Purpose: shared constants and types for the shift/rotate and table opcode decoder
// Assumes: 16-bit instruction words, APB register access with 32-bit data
// Notes: register offsets are byte addresses of aligned words
package decode_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] DEC_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] WORDS_OFS = 8'h0C;
	localparam logic CTRL_EN_RST = 1'h1;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

	// ****************************************
	// opcode fields
	// ****************************************
	localparam logic [3:0] SHIFT_GRP = 4'hE;
	localparam logic [9:0] TBL_PREFIX = 10'h3E0;
	localparam logic [2:0] ZERO3 = 3'h0;
	localparam logic [5:0] ZERO6 = 6'h00;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;
	localparam logic [1:0] SZ_MEM = 2'h3;
	localparam logic [1:0] KIND_ARITH = 2'h0;
	localparam logic [1:0] KIND_LOGICAL = 2'h1;
	localparam logic [1:0] KIND_EXT_ROT = 2'h2;
	localparam logic [1:0] KIND_ROT = 2'h3;
	localparam logic [1:0] TBL_REG_FORM = 2'h0;
	localparam logic [1:0] TBL_LOOKUP_FORM = 2'h1;

	typedef enum logic [3:0]
	{
		no_group_op = 4'h0,
		arith_shift_right_op = 4'h1,
		arith_shift_left_op = 4'h2,
		logical_shift_right_op = 4'h3,
		logical_shift_left_op = 4'h4,
		extend_rotate_right_op = 4'h5,
		extend_rotate_left_op = 4'h6,
		plain_rotate_right_op = 4'h7,
		plain_rotate_left_op = 4'h8,
		unsigned_plain_interp_op = 4'h9,
		unsigned_rounded_interp_op = 4'hA,
		signed_plain_interp_op = 4'hB,
		signed_rounded_interp_op = 4'hC
	} op_t;

	typedef enum logic
	{
		ST_FIRST = 1'h0,
		ST_EXT = 1'h1
	} dec_state_t;

	typedef struct packed
	{
		logic valid;
		logic [15:0] word;
	} fetch_t;

	// 31 bits; read back through DEC_OFS with bit 31 zero
	typedef struct packed
	{
		op_t op;
		logic illegal;
		logic is_mem;
		logic count_is_reg;
		logic [2:0] count_or_reg;
		logic dir_left;
		logic [1:0] size;
		logic [2:0] dst_reg;
		logic [5:0] ea;
		logic tbl_reg_form;
		logic tbl_signed;
		logic tbl_round;
		logic [2:0] index_operand_reg;
		logic [2:0] end_reg2;
	} decode_t;

endpackage

// [rtl/instr_field_decoder.sv]
// Purpose: combinational field decode of one instruction word and its extension word
// Assumes: ext_word only meaningful when ext_present is high
// Notes: words outside both groups decode as no_group_op with illegal low
`timescale 1ns/1ps
module instr_field_decoder
(
	// words
	input wire logic [15:0] first_word,
	input wire logic [15:0] ext_word,
	input wire logic ext_present,
	// result
	output decode_pkg::decode_t dec,
	output logic needs_ext
);
	import decode_pkg::*;

	function automatic logic size_legal(input logic [1:0] sz);
		size_legal = (sz != SZ_MEM);
	endfunction

	function automatic op_t shift_op(input logic [1:0] kind, input logic left);
		case (kind)
			KIND_ARITH: shift_op = left ? arith_shift_left_op : arith_shift_right_op;
			KIND_LOGICAL: shift_op = left ? logical_shift_left_op : logical_shift_right_op;
			KIND_EXT_ROT: shift_op = left ? extend_rotate_left_op : extend_rotate_right_op;
			default: shift_op = left ? plain_rotate_left_op : plain_rotate_right_op;
		endcase
	endfunction

	logic is_shift;
	logic is_table;
	logic reg_form_ok;
	logic lookup_ok;

	assign is_shift = (first_word[15:12] == SHIFT_GRP);
	assign is_table = (first_word[15:6] == TBL_PREFIX);
	assign needs_ext = is_table;
	// data-register form: first word is the prefix with mode zero, extension bits 9-8 zero
	assign reg_form_ok = (first_word[5:3] == ZERO3) && (ext_word[9:8] == TBL_REG_FORM)
		&& (ext_word[5:3] == ZERO3);
	// lookup form: bit 15 and bits 5-0 of the extension clear, bits 9-8 are 01
	assign lookup_ok = !ext_word[15] && (ext_word[9:8] == TBL_LOOKUP_FORM)
		&& (ext_word[5:0] == ZERO6);

	always_comb
	begin
		dec = '0;
		dec.op = no_group_op;
		if (is_shift)
		begin
			dec.dir_left = first_word[8];
			if (size_legal(first_word[7:6]))
			begin
				dec.size = first_word[7:6];
				dec.count_is_reg = first_word[5];
				// immediate count or count register number, by the count-source bit
				dec.count_or_reg = first_word[11:9];
				dec.dst_reg = first_word[2:0];
				dec.op = shift_op(first_word[4:3], first_word[8]);
			end
			else if (!first_word[11])
			begin
				dec.is_mem = 1'b1;
				dec.size = SZ_WORD;
				dec.ea = first_word[5:0];
				dec.op = shift_op(first_word[10:9], first_word[8]);
			end
			else
			begin
				dec.illegal = 1'b1;
			end
		end
		else if (is_table && ext_present)
		begin
			dec.tbl_reg_form = reg_form_ok;
			dec.ea = first_word[5:0];
			dec.dst_reg = first_word[2:0];
			dec.index_operand_reg = ext_word[14:12];
			dec.tbl_signed = ext_word[11];
			dec.tbl_round = ext_word[10];
			dec.size = ext_word[7:6];
			dec.end_reg2 = reg_form_ok ? ext_word[2:0] : ZERO3;
			if (!(reg_form_ok || lookup_ok) || !size_legal(ext_word[7:6]))
			begin
				dec.illegal = 1'b1;
			end
			else
			begin
				// signedness picks the result kind, rounding picks rounded or not
				case ({ext_word[11], ext_word[10]})
					2'h0: dec.op = unsigned_plain_interp_op;
					2'h1: dec.op = unsigned_rounded_interp_op;
					2'h2: dec.op = signed_plain_interp_op;
					default: dec.op = signed_rounded_interp_op;
				endcase
			end
		end
	end

endmodule

// [tb/fetch_model.sv]
// Purpose: behavioural fetch stage that offers instruction words to the decoder
// Assumes: each word is offered for exactly one cycle, with no handshake
// Notes: after a word the lines carry its inverse and toggle in gap cycles, so stale words never look stable
`timescale 1ns/1ps
module fetch_model
(
	// clock
	input wire logic pclk,
	// words towards the decoder
	output decode_pkg::fetch_t fetch
);
	import decode_pkg::*;

	initial fetch = '{valid: 1'b0, word: 16'h0000};

	// gap inserts idle cycles so slow fetch is exercised; even gap 0 leaves an idle cycle between words
	task automatic send(input logic [15:0] w, input int gap);
		repeat (gap) @(posedge pclk) fetch <= '{valid: 1'b0, word: ~fetch.word};
		@(posedge pclk);
		fetch <= '{valid: 1'b1, word: w};
		@(posedge pclk);
		fetch <= '{valid: 1'b0, word: ~w};
	endtask
endmodule

// [tb/test_shift_rotate_table_opcode_decoder.sv]
// Purpose: self-checking bench for the shift/rotate and table opcode decoder
// Assumes: words come through fetch_model, registers through APB
// Notes: random words come from a fixed xorshift seed
`timescale 1ns/1ps
module test_shift_rotate_table_opcode_decoder;
	import decode_pkg::*;

	// ****************************************
	// signals and instances
	// ****************************************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	fetch_t fetch;
	logic dec_valid;
	decode_t dec_out;
	logic waiting_ext;
	int fails = 0;
	int samples_checked = 0;
	int ndec = 0;
	logic [31:0] seed = 32'h0001_7996;
	logic [31:0] rd;
	logic err;

	always #4 pclk = ~pclk;

	fetch_model fetch_model_inst (.pclk(pclk), .fetch(fetch));
	shift_table_decoder shift_table_decoder_inst
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fetch(fetch), .dec_valid(dec_valid), .dec_out(dec_out), .waiting_ext(waiting_ext)
	);

	// ****************************************
	// tasks
	// ****************************************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [3:0] shop(input logic [1:0] kind, input logic left);
		return {1'b0, kind, 1'b0} + (left ? 4'h2 : 4'h1);
	endfunction

	task automatic conclude();
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		// a late answer on the last allowed edge is still an answer
		if (pready !== 1'b1)
		begin
			fails++;
			conclude();
		end
		else
		begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// decode must pulse for exactly the cycle after the word is taken
	task automatic word_dec(input logic [15:0] w);
		fetch_model_inst.send(w, xs() % 3);
		#1;
		chk("dec_valid", 32'h0000_0001, {31'h0, dec_valid});
		@(posedge pclk);
		#1;
		chk("dec_pulse", 32'h0000_0000, {31'h0, dec_valid});
		ndec++;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	initial
	begin
		#400000;
		fails++;
		conclude();
	end

	initial
	begin
		logic [31:0] r;
		logic [15:0] w;
		logic [15:0] x;
		logic [1:0] sz;
		logic lk;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b0, 8'(i * 4), 32'h0000_0000);
			chk("reset_reg", (i == 0) ? 32'h0000_0001 : 32'h0000_0000, rd);
			chk("slverr", {31'h0, i == 4}, {31'h0, err});
		end
		for (int i = 0; i < 48; i++)
		begin
			r = xs();
			w = {4'hE, r[11:0]};
			if (w[7:6] == 2'b11)
				w[7] = 1'b0;
			if (i < 2)
				w[11:9] = i ? 3'h7 : 3'h0;
			word_dec(w);
			r = {16'h0, shop(w[4:3], w[8]), 2'b00, w[5], w[11:9], w[8], w[7:6], w[2:0]};
			w = {dec_out.op, dec_out.illegal, dec_out.is_mem, dec_out.count_is_reg,
				dec_out.count_or_reg, dec_out.dir_left, dec_out.size, dec_out.dst_reg};
			chk("shift_reg", r, {16'h0, w});
		end
		for (int i = 0; i < 16; i++)
		begin
			r = xs();
			w = {4'hE, i == 0, r[10:8], 2'b11, r[5:0]};
			word_dec(w);
			x = w[11] ? 16'h0001 : {11'h0, shop(w[10:9], w[8]), 1'b0};
			chk("shift_mem", x, {11'h0, dec_out.op, dec_out.illegal});
			if (!w[11])
				chk("mem_fields", {w[8], 2'b01, w[5:0]}, {dec_out.dir_left, dec_out.size, dec_out.ea});
		end
		word_dec(16'hC148);
		chk("no_group", 32'h0000_0000, {27'h0, dec_out.op, dec_out.illegal});
		for (int i = 0; i < 32; i++)
		begin
			r = xs();
			lk = i[2];
			sz = (r[1:0] == 2'b11) ? 2'b10 : r[1:0];
			w = lk ? {10'h3E0, r[10:5]} : {13'h1F00, r[7:5]};
			x = {lk ? 1'b0 : r[15], r[4:2], i[0], i[1], 1'b0, lk, sz, 3'h0, lk ? 3'h0 : r[13:11]};
			if (i >= 24 && lk)
				x[15] = 1'b1;
			fetch_model_inst.send(w, r[17:16]);
			#1;
			chk("waiting_ext", 32'h0000_0001, {31'h0, waiting_ext});
			word_dec(x);
			chk("ext_done", 32'h0000_0000, {31'h0, waiting_ext});
			chk("tbl_illegal", {31'h0, x[15] & lk}, {31'h0, dec_out.illegal});
			if (!(x[15] & lk))
			begin
				chk("tbl_op", {4'h9 + {2'b00, i[0], i[1]}, !lk, i[0], i[1], x[14:12], sz},
					{dec_out.op, dec_out.tbl_reg_form, dec_out.tbl_signed, dec_out.tbl_round,
					dec_out.index_operand_reg, dec_out.size});
				chk("tbl_regs", lk ? w[5:0] : {w[2:0], x[2:0]},
					lk ? dec_out.ea : {dec_out.dst_reg, dec_out.end_reg2});
			end
		end
		apb(1'b1, CTRL_OFS, 32'h0000_0000);
		fetch_model_inst.send(16'hE148, 0);
		#1;
		chk("disabled", 32'h0000_0000, {31'h0, dec_valid});
		apb(1'b1, CTRL_OFS, 32'h0000_0001);
		fetch_model_inst.send(16'hF803, 0);
		#1;
		chk("held_first", 32'h0000_0001, {31'h0, waiting_ext});
		apb(1'b1, CTRL_OFS, 32'h0000_0000);
		// enable falls on the access edge, the held word is dropped one edge later
		@(posedge pclk);
		#1;
		chk("drop_held", 32'h0000_0000, {31'h0, waiting_ext});
		apb(1'b1, CTRL_OFS, 32'h0000_0001);
		apb(1'b0, STATUS_OFS, 32'h0000_0000);
		chk("count", 32'(ndec), {16'h0, rd[31:16]});
		apb(1'b1, STATUS_OFS, 32'h0000_0000);
		apb(1'b0, STATUS_OFS, 32'h0000_0000);
		chk("count_clr", 32'h0000_0000, {16'h0, rd[31:16]});
		conclude();
	end
endmodule
